// File: rtl/mids_screen_top.sv
// Message ID screening: control registers, bit scan and frame decision
//
// Contract
// - Comparison starts offset plus one bits after sync
// - Screening runs only while enable bit set
// - Organisation bit picks two or four byte entries
// - Four byte mode compares code plus one bytes
// - Two byte mode compares one or two bytes
// - Reference bytes write only, cleared at reset
`timescale 1ns/1ps
`default_nettype none
`include "mids_params.svh"

module mids_screen_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic frame_sync_event,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  output logic frame_accept,
  output logic frame_reject,
  output logic [3:0] match_index,
  output logic screening_busy
);
  import mids_pkg::*;

  // ==========================================
  // Register state
  logic [7:0] scan_start_reg;
  logic [7:0] screen_ctrl_reg;
  logic [7:0] accept_cnt_reg;
  logic [7:0] reject_cnt_reg;
  logic last_accept_reg;
  logic last_reject_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // ==========================================
  // Scan state
  mids_state_t state_reg;
  mids_state_t state_next;
  logic [6:0] skip_cnt_reg;
  logic [6:0] skip_cnt_next;
  logic [5:0] bit_cnt_reg;
  logic [5:0] bit_cnt_next;
  logic [31:0] rx_shift_reg;
  logic [31:0] rx_shift_next;
  logic accept_reg;
  logic reject_reg;
  logic [3:0] index_reg;

  // ==========================================
  // Address decode
  wire hit_ref;
  wire hit_scan_start;
  wire hit_screen_ctrl;
  wire hit_status;
  wire hit_accept_cnt;
  wire hit_reject_cnt;
  wire ref_wr_en;
  wire [4:0] ref_wr_index;

  assign hit_ref = (reg_addr <= `MIDS_ADDR_REF_LAST);
  assign hit_scan_start = (reg_addr == `MIDS_ADDR_SCAN_START);
  assign hit_screen_ctrl = (reg_addr == `MIDS_ADDR_SCREEN_CTRL);
  assign hit_status = (reg_addr == `MIDS_ADDR_STATUS);
  assign hit_accept_cnt = (reg_addr == `MIDS_ADDR_ACCEPT_CNT);
  assign hit_reject_cnt = (reg_addr == `MIDS_ADDR_REJECT_CNT);
  assign ref_wr_en = reg_wr && hit_ref;
  assign ref_wr_index = reg_addr[4:0];

  // ==========================================
  // Control fields
  wire [6:0] scan_start_offset;
  wire screening_enable;
  mids_org_t id_byte_organisation;
  wire [1:0] bytes_to_compare;

  assign scan_start_offset = scan_start_reg[`MIDS_OFS_MSB:0];
  assign screening_enable = screen_ctrl_reg[`MIDS_EN_BIT];
  assign id_byte_organisation = mids_org_t'(screen_ctrl_reg[`MIDS_ORG_BIT]);
  assign bytes_to_compare = screen_ctrl_reg[`MIDS_NTS_MSB:0];

  // ==========================================
  // Byte count and bit count per mode
  wire [2:0] byte_count;
  wire [5:0] total_bits;
  wire [5:0] align_shift;
  wire [31:0] rx_aligned;

  // Four byte mode: code plus one; two byte mode: 00 one, else two
  assign byte_count = (id_byte_organisation == MIDS_ORG_4BYTE) ?
                      ({1'b0, bytes_to_compare} + 3'h1) :
                      ((bytes_to_compare == 2'h0) ? 3'h1 : 3'h2);
  assign total_bits = {byte_count, 3'h0};
  assign align_shift = `MIDS_MAX_BITS - total_bits;
  // First received byte lands in bits 31:24
  assign rx_aligned = rx_shift_reg << align_shift;

  // ==========================================
  // Stored reference bytes
  logic [159:0] ref_flat;

  mids_ref_store u_ref_store (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_en(ref_wr_en),
    .wr_index(ref_wr_index),
    .wr_data(reg_wdata),
    .ref_flat(ref_flat)
  );

  // ==========================================
  // Comparison against all entries
  logic any_match;
  logic [3:0] cmp_index;

  mids_id_compare u_id_compare (
    .ref_flat(ref_flat),
    .rx_aligned(rx_aligned),
    .org(id_byte_organisation),
    .byte_count(byte_count),
    .any_match(any_match),
    .match_index(cmp_index)
  );

  // ==========================================
  // Control register writes, unused bits forced to zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scan_start_reg <= `MIDS_REG_RST;
      screen_ctrl_reg <= `MIDS_REG_RST;
    end else if (reg_wr) begin
      if (hit_scan_start) begin
        scan_start_reg <= {1'b0, reg_wdata[6:0]};
      end
      if (hit_screen_ctrl) begin
        screen_ctrl_reg <= {4'h0, reg_wdata[3:0]};
      end
    end
  end

  // ==========================================
  // Scan sequencer next state
  wire start_scan;
  wire last_bit;

  assign start_scan = frame_sync_event && screening_enable;
  assign last_bit = (bit_cnt_reg == (total_bits - 6'h01));

  always_comb begin
    state_next = state_reg;
    skip_cnt_next = skip_cnt_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_shift_next = rx_shift_reg;
    if (!screening_enable) begin
      // Disabling mid scan drops the frame decision
      state_next = MIDS_IDLE;
    end else if (start_scan) begin
      // New sync restarts the scan at any point
      skip_cnt_next = scan_start_offset;
      bit_cnt_next = 6'h00;
      rx_shift_next = 32'h0000_0000;
      state_next = (scan_start_offset == 7'h00) ? MIDS_COLLECT : MIDS_SKIP;
    end else begin
      unique case (state_reg)
        MIDS_IDLE: begin
          state_next = MIDS_IDLE;
        end
        MIDS_SKIP: begin
          // Drop offset bits, next bit is first compared
          if (rx_bit_valid) begin
            skip_cnt_next = skip_cnt_reg - 7'h01;
            if (skip_cnt_reg == 7'h01) begin
              state_next = MIDS_COLLECT;
            end
          end
        end
        MIDS_COLLECT: begin
          // Gather bytes, first bit received is the byte MSB
          if (rx_bit_valid) begin
            rx_shift_next = {rx_shift_reg[30:0], rx_bit};
            bit_cnt_next = bit_cnt_reg + 6'h01;
            if (last_bit) begin
              state_next = MIDS_DECIDE;
            end
          end
        end
        MIDS_DECIDE: begin
          state_next = MIDS_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Scan sequencer registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= MIDS_IDLE;
      skip_cnt_reg <= 7'h00;
      bit_cnt_reg <= 6'h00;
      rx_shift_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      skip_cnt_reg <= skip_cnt_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_shift_reg <= rx_shift_next;
    end
  end

  // ==========================================
  // Frame decision pulses
  wire decide_now;
  wire bypass_now;

  assign decide_now = (state_reg == MIDS_DECIDE) && screening_enable && !frame_sync_event;
  // Without screening every synchronised frame passes
  assign bypass_now = frame_sync_event && !screening_enable;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      accept_reg <= 1'b0;
      reject_reg <= 1'b0;
      index_reg <= 4'h0;
    end else begin
      accept_reg <= bypass_now || (decide_now && any_match);
      reject_reg <= decide_now && !any_match;
      if (decide_now && any_match) begin
        index_reg <= cmp_index;
      end
    end
  end

  // ==========================================
  // Status flags and frame counters
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      last_accept_reg <= 1'b0;
      last_reject_reg <= 1'b0;
      accept_cnt_reg <= 8'h00;
      reject_cnt_reg <= 8'h00;
    end else begin
      if (accept_reg || reject_reg) begin
        last_accept_reg <= accept_reg;
        last_reject_reg <= reject_reg;
      end
      if (accept_reg) begin
        accept_cnt_reg <= accept_cnt_reg + 8'h01;
      end
      if (reject_reg) begin
        reject_cnt_reg <= reject_cnt_reg + 8'h01;
      end
    end
  end

  // ==========================================
  // Read mux, write-only registers read as zero
  wire [7:0] status_word;

  assign status_word = {index_reg, 1'b0, last_reject_reg, last_accept_reg, screening_busy};

  always_comb begin
    rdata_next = 8'h00;
    if (hit_status) begin
      rdata_next = status_word;
    end else if (hit_accept_cnt) begin
      rdata_next = accept_cnt_reg;
    end else if (hit_reject_cnt) begin
      rdata_next = reject_cnt_reg;
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd ? rdata_next : 8'h00;
    end
  end

  // ==========================================
  // Outputs
  assign reg_rdata = rdata_reg;
  assign frame_accept = accept_reg;
  assign frame_reject = reject_reg;
  assign match_index = index_reg;
  assign screening_busy = (state_reg != MIDS_IDLE);

endmodule
`default_nettype wire

// File: common/mids_params.svh
// Register offsets, field positions, reset values and sizes for ID screening
`ifndef MIDS_PARAMS_SVH
`define MIDS_PARAMS_SVH

// ==========================================
// Register offsets
`define MIDS_ADDR_REF_FIRST 8'h00
`define MIDS_ADDR_REF_LAST 8'h13
`define MIDS_ADDR_SCAN_START 8'h14
`define MIDS_ADDR_SCREEN_CTRL 8'h15
`define MIDS_ADDR_STATUS 8'h20
`define MIDS_ADDR_ACCEPT_CNT 8'h21
`define MIDS_ADDR_REJECT_CNT 8'h22

// ==========================================
// Field positions
`define MIDS_OFS_MSB 6
`define MIDS_EN_BIT 3
`define MIDS_ORG_BIT 2
`define MIDS_NTS_MSB 1

// ==========================================
// Reset values and sizes
`define MIDS_REG_RST 8'h00
`define MIDS_REF_BYTES 20
`define MIDS_ENTRIES_2B 10
`define MIDS_ENTRIES_4B 5
`define MIDS_MAX_BITS 6'h20

`endif

// File: common/mids_pkg.sv
// Types shared by the ID screening files
package mids_pkg;

  // Scan sequencer states
  typedef enum logic [1:0] {
    MIDS_IDLE = 2'b00,
    MIDS_SKIP = 2'b01,
    MIDS_COLLECT = 2'b10,
    MIDS_DECIDE = 2'b11
  } mids_state_t;

  // Reference ID layout
  typedef enum logic {
    MIDS_ORG_2BYTE = 1'b0,
    MIDS_ORG_4BYTE = 1'b1
  } mids_org_t;

endpackage

// File: rtl/mids_ref_store.sv
// Reference ID byte registers, write only, cleared at reset
`timescale 1ns/1ps
`default_nettype none
`include "mids_params.svh"

module mids_ref_store (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [4:0] wr_index,
  input wire logic [7:0] wr_data,
  output logic [159:0] ref_flat
);
  import mids_pkg::*;

  // ==========================================
  // One byte register per reference byte
  logic [7:0] ref_mem [0:`MIDS_REF_BYTES-1];

  genvar i;
  generate
    for (i = 0; i < `MIDS_REF_BYTES; i = i + 1) begin : g_byte
      // Byte write on index hit
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          ref_mem[i] <= `MIDS_REG_RST;
        end else if (wr_en && (wr_index == 5'(i))) begin
          ref_mem[i] <= wr_data;
        end
      end
      assign ref_flat[i*8 +: 8] = ref_mem[i];
    end
  endgenerate

endmodule
`default_nettype wire

// File: rtl/mids_id_compare.sv
// Compares collected bytes against every stored reference entry
`timescale 1ns/1ps
`default_nettype none
`include "mids_params.svh"

module mids_id_compare (
  input wire logic [159:0] ref_flat,
  input wire logic [31:0] rx_aligned,
  input wire mids_pkg::mids_org_t org,
  input wire logic [2:0] byte_count,
  output logic any_match,
  output logic [3:0] match_index
);
  import mids_pkg::*;

  // ==========================================
  // Per-entry hits, first received byte against lowest byte
  logic [`MIDS_ENTRIES_2B-1:0] hit_2b;
  logic [`MIDS_ENTRIES_4B-1:0] hit_4b;
  logic [`MIDS_ENTRIES_2B-1:0] hit_sel;

  genvar e;
  generate
    for (e = 0; e < `MIDS_ENTRIES_2B; e = e + 1) begin : g_two
      assign hit_2b[e] = (rx_aligned[31:24] == ref_flat[e*16 +: 8]) &&
                         ((byte_count < 3'h2) ||
                          (rx_aligned[23:16] == ref_flat[e*16+8 +: 8]));
    end
    for (e = 0; e < `MIDS_ENTRIES_4B; e = e + 1) begin : g_four
      assign hit_4b[e] = (rx_aligned[31:24] == ref_flat[e*32 +: 8]) &&
                         ((byte_count < 3'h2) ||
                          (rx_aligned[23:16] == ref_flat[e*32+8 +: 8])) &&
                         ((byte_count < 3'h3) ||
                          (rx_aligned[15:8] == ref_flat[e*32+16 +: 8])) &&
                         ((byte_count < 3'h4) ||
                          (rx_aligned[7:0] == ref_flat[e*32+24 +: 8]));
    end
  endgenerate

  // Mode selects the entry set
  assign hit_sel = (org == MIDS_ORG_4BYTE) ? {5'h00, hit_4b} : hit_2b;
  assign any_match = |hit_sel;

  // Lowest matching entry wins
  always_comb begin
    match_index = 4'h0;
    for (int k = `MIDS_ENTRIES_2B - 1; k >= 0; k = k - 1) begin
      if (hit_sel[k]) begin
        match_index = 4'(k);
      end
    end
  end

endmodule
`default_nettype wire

// File: tb/mids_screen_props.sv
// Port assertions for the ID screening block
`timescale 1ns/1ps
`default_nettype none
module mids_screen_props (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic frame_sync_event,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic frame_accept,
  input wire logic frame_reject,
  input wire logic [3:0] match_index,
  input wire logic screening_busy
);
  logic en_reg, org_reg;
  logic [1:0] nts_reg;
  logic [6:0] ofs_reg;
  logic [7:0] cnt_reg;
  logic [2:0] nbytes;
  logic [7:0] total;
  logic done;
  // Bits expected per frame from the shadowed fields
  assign nbytes = org_reg ? {1'b0, nts_reg} + 3'h1 : (nts_reg == 2'h0 ? 3'h1 : 3'h2);
  assign total = {1'b0, ofs_reg} + {2'h0, nbytes, 3'h0};
  assign done = frame_accept | frame_reject;
  // ==========
  // Shadow of control fields and bits taken
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      {en_reg, org_reg, nts_reg, ofs_reg} <= 11'h000;
      cnt_reg <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == 8'h14) ofs_reg <= reg_wdata[6:0];
      if (reg_wr && reg_addr == 8'h15) {en_reg, org_reg, nts_reg} <= reg_wdata[3:0];
      if (frame_sync_event) cnt_reg <= 8'h00;
      else if (screening_busy && rx_bit_valid) cnt_reg <= cnt_reg + 8'h01;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // Checks
  one_verdict_a: assert property (!(frame_accept && frame_reject)) else $error("accept and reject together");
  wo_read_zero_a: assert property (reg_rd && reg_addr <= 8'h15 |=> reg_rdata == 8'h00)
    else $error("write-only register read nonzero");
  bypass_pass_a: assert property (frame_sync_event && !en_reg && !screening_busy |=> frame_accept && !frame_reject)
    else $error("disabled sync not accepted");
  scan_start_a: assert property (frame_sync_event && en_reg |=> screening_busy) else $error("scan not started");
  last_bit_a: assert property (screening_busy && rx_bit_valid && cnt_reg == total - 8'h01 |-> ##2 done)
    else $error("no decision two cycles after last bit");
  bit_count_a: assert property (done && $past(screening_busy) |-> cnt_reg == total)
    else $error("decision after wrong bit count");
  end_verdict_a: assert property ($fell(screening_busy) && en_reg && !$past(reg_wr) |-> done)
    else $error("scan ended without decision");
  index_hold_a: assert property (!frame_accept |-> $stable(match_index)) else $error("match index moved");
endmodule
`default_nettype wire

// File: tb/mids_sync_model.sv
// Frame synchronizer model: sync pulse, filler bits, payload
`timescale 1ns/1ps
`default_nettype none
module mids_sync_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic slow,
  input wire logic [6:0] skip,
  input wire logic [5:0] nbits,
  input wire logic [31:0] payload,
  output logic frame_sync_event,
  output logic rx_bit_valid,
  output logic rx_bit
);
  logic [7:0] left_reg;
  logic [31:0] shift_reg;
  logic phase_reg;
  // ==========
  // Payload goes MSB first; line toggles between bits so no stale value
  always_ff @(posedge ref_clk) begin
    frame_sync_event <= 1'b0;
    rx_bit_valid <= 1'b0;
    phase_reg <= ~phase_reg;
    if (sys_rst) begin
      left_reg <= 8'h00;
      rx_bit <= 1'b0;
      phase_reg <= 1'b0;
    end else if (go) begin
      frame_sync_event <= 1'b1;
      left_reg <= {1'b0, skip} + {2'h0, nbits};
      shift_reg <= payload;
      phase_reg <= 1'b0;
    end else if (left_reg != 8'h00 && (!slow || phase_reg)) begin
      rx_bit_valid <= 1'b1;
      left_reg <= left_reg - 8'h01;
      rx_bit <= (left_reg > {2'h0, nbits}) ? left_reg[0] : shift_reg[31];
      if (left_reg <= {2'h0, nbits}) shift_reg <= {shift_reg[30:0], 1'b0};
    end else begin
      rx_bit <= ~rx_bit;
    end
  end
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the ID screening block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk, sys_rst, reg_wr, reg_rd, frame_sync_event, rx_bit_valid, rx_bit;
  logic frame_accept, frame_reject, screening_busy, go, slow;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] match_index;
  logic [6:0] skip;
  logic [5:0] nbits;
  logic [31:0] payload;
  int fails = 0;
  int samples_checked = 0;
  mids_screen_top i_mids_screen_top (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .frame_sync_event, .rx_bit_valid, .rx_bit, .frame_accept, .frame_reject, .match_index, .screening_busy);
  mids_sync_model i_mids_sync_model (.ref_clk, .sys_rst, .go, .slow, .skip, .nbits, .payload,
    .frame_sync_event, .rx_bit_valid, .rx_bit);
  // Clock at 50 MHz
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ==========
  // Shared tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic final_report;
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", {24'h0, exp}, {24'h0, reg_rdata});
    @(posedge ref_clk);
  endtask
  // Configure, send one frame, judge the decision
  task automatic frame(input logic [7:0] ctrl, input logic [6:0] ofs, input logic [31:0] pl, input logic sl,
    input logic acc, input logic [3:0] idx);
    int n;
    wr(8'h14, {1'b0, ofs});
    wr(8'h15, ctrl);
    skip <= ofs;
    nbits <= ctrl[2] ? 6'h08 * ({4'h0, ctrl[1:0]} + 6'h01) : (ctrl[1:0] == 2'h0 ? 6'h08 : 6'h10);
    payload <= pl;
    slow <= sl;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    for (n = 0; n < 400; n++) begin
      @(posedge ref_clk);
      #1;
      if (frame_accept === 1'b1 || frame_reject === 1'b1) break;
    end
    if (n == 400) begin
      fails++;
      $display("CHECK FAILED decision expected pulse seen none");
      final_report();
    end
    check("decision", {30'h0, acc, !acc}, {30'h0, frame_accept, frame_reject});
    if (ctrl[3] && acc) check("match_index", {28'h0, idx}, {28'h0, match_index});
    @(posedge ref_clk);
  endtask
  // ==========
  // Scenarios
  task automatic sc_reset_values;
    logic [7:0] addrs [8] = '{8'h00, 8'h13, 8'h14, 8'h15, 8'h20, 8'h21, 8'h22, 8'h30};
    foreach (addrs[i]) rd(addrs[i], 8'h00);
  endtask
  task automatic sc_bypass;
    frame(8'h00, 7'h00, 32'h55000000, 1'b0, 1'b1, 4'h0);
    rd(8'h21, 8'h01);
  endtask
  task automatic sc_two_byte;
    for (int i = 0; i < 20; i++) wr(i[7:0], 8'h10 + i[7:0]);
    rd(8'h05, 8'h00);
    frame(8'h08, 7'h00, 32'h12000000, 1'b0, 1'b1, 4'h1);
    frame(8'h0B, 7'h05, 32'h18190000, 1'b1, 1'b1, 4'h4);
    frame(8'h09, 7'h00, 32'h12140000, 1'b0, 1'b0, 4'h0);
  endtask
  task automatic sc_four_byte;
    for (int c = 0; c < 4; c++) frame(8'h0C | c[7:0], (c == 3) ? 7'h7F : c[6:0], 32'h18191A1B, c[0], 1'b1, 4'h2);
    frame(8'h0F, 7'h00, 32'h18191A1C, 1'b0, 1'b0, 4'h0);
    // Totals over all frames so far, then last verdict and kept index
    rd(8'h21, 8'h07);
    rd(8'h22, 8'h02);
    rd(8'h20, 8'h24);
  endtask
  // Main sequence
  initial begin
    {sys_rst, reg_wr, reg_rd, go, slow} = 5'h10;
    {reg_addr, reg_wdata, skip, nbits, payload} = 61'h0;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    sc_reset_values();
    sc_bypass();
    sc_two_byte();
    sc_four_byte();
    final_report();
  end
endmodule
bind mids_screen_top mids_screen_props i_mids_screen_props (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .frame_sync_event, .rx_bit_valid, .rx_bit, .frame_accept, .frame_reject, .match_index,
  .screening_busy);
`default_nettype wire
